//--- inc/adc_seq_pkg.sv
// constants, register map and state codes of the conversion sequencer
// assumes a 25 MHz system clock and an APB bus with 32-bit data
package adc_seq_pkg;
  localparam int ADDR_W = 8;
  localparam int RES_W = 10;
  localparam int TRIG_W = 5;
  localparam int TRIG_N = 18;

  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RESH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RESL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14;

  localparam int BIT_EN = 0;
  localparam int BIT_GO = 1;
  localparam int POS_CHAN = 2;
  localparam int BIT_JUST = 7;
  localparam int POS_CLKSEL = 4;
  localparam int POS_PREF = 0;
  localparam int BIT_DONE = 0;
  localparam int BIT_IRQEN = 1;

  localparam logic [5:0] RST_CHAN = 6'h00;
  localparam logic [2:0] RST_CLKSEL = 3'h0;
  localparam logic [1:0] RST_PREF = 2'h0;
  localparam logic [TRIG_W-1:0] RST_TRIG = 5'h00;

  localparam int CLK_NS = 40;
  localparam int FOSC_PER_INSTR = 4;
  localparam int INSTR_NS = CLK_NS * FOSC_PER_INSTR;
  localparam int INSTR_CLKS = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_HALF_TADS = 23;
  localparam logic [4:0] LAST_HALF = 5'(CONV_HALF_TADS - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_DELAY = 3'h2,
    ST_CONV = 3'h4
  } state_t;

  function automatic logic isRcClock(input logic [2:0] sel);
    return sel[1:0] == 2'h3;
  endfunction : isRcClock
endpackage : adc_seq_pkg

//--- rtl/trigger_sync.sv
// auto-trigger source synchroniser, selector and rising edge detector
// assumes sources come from other on-chip blocks, possibly asynchronous
`timescale 1ns/1ps
module trigger_sync #(
  parameter int N = adc_seq_pkg::TRIG_N
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [N-1:0] sources,
  input wire logic [adc_seq_pkg::TRIG_W-1:0] sel,
  output logic pulse
);
  import adc_seq_pkg::*;

  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic prev_r;
  logic selected;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sources;
      sync2_r <= sync1_r;
    end
  end

  // codes above the source count select nothing
  always_comb begin
    selected = 1'b0;
    if (sel != '0 && int'(sel) <= N) begin
      selected = sync2_r[int'(sel) - 1];
    end
  end

  // changing the selection while the new source is high may give one pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 1'b0;
      pulse <= 1'b0;
    end else begin
      prev_r <= selected;
      pulse <= selected & ~prev_r;
    end
  end
endmodule : trigger_sync

//--- rtl/tad_divider.sv
// half bit-period tick generator for the converter
// assumes rcHalfTick is a one-cycle pulse already in the clk domain
`timescale 1ns/1ps
module tad_divider (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [2:0] clkSel,
  input wire logic rcHalfTick,
  output logic halfTick
);
  import adc_seq_pkg::*;

  logic [5:0] cnt_r;
  logic [5:0] halfLast;
  logic [2:0] expo;

  // sel 000,100,001,101,010,110 give Fosc/2 to Fosc/64
  always_comb begin
    expo = {clkSel[1:0], 1'b0} + {2'h0, clkSel[2]};
    halfLast = 6'((7'h01 << expo) - 7'h01);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 6'h00;
      halfTick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 6'h00;
      halfTick <= 1'b0;
    end else if (isRcClock(clkSel)) begin
      cnt_r <= 6'h00;
      halfTick <= rcHalfTick;
    end else if (cnt_r == halfLast) begin
      cnt_r <= 6'h00;
      halfTick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 6'h01;
      halfTick <= 1'b0;
    end
  end
endmodule : tad_divider

//--- rtl/adc_conversion_sequencer.sv
// sequencer for a 10-bit successive approximation converter, APB slave
// assumes the analog comparator result compIn is valid one cycle after dacCode
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module adc_conversion_sequencer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepMode,
  input wire logic [adc_seq_pkg::TRIG_N-1:0] trigSources,
  input wire logic rcHalfTick,
  input wire logic compIn,
  output logic [adc_seq_pkg::RES_W-1:0] dacCode,
  output logic convOn,
  output logic [5:0] chanSel,
  output logic [1:0] refSel,
  output logic wakeRequest
);
  import adc_seq_pkg::*;

  state_t state_r;
  logic enable_r;
  logic go_r;
  logic justify_r;
  logic [2:0] clkSel_r;
  logic [TRIG_W-1:0] trigSel_r;
  logic irqEn_r;
  logic doneFlag_r;
  logic powerDown_r;
  logic [7:0] resH_r;
  logic [7:0] resL_r;
  logic [4:0] halfCnt_r;
  logic [2:0] dlyCnt_r;
  logic [3:0] bitIdx_r;
  logic [31:0] rdMux;
  logic mapped;
  logic halfTick;
  logic trigPulse;
  logic rcSel;
  logic idle;
  logic wrXfer;
  logic wrCtrl0;
  logic swGoSet;
  logic swGoClr;
  logic disableNow;
  logic sleepAbort;
  logic startOk;
  logic complete;
  logic resolveNow;
  logic abortAny;
  logic [15:0] partialPlaced;
  logic [15:0] finalPlaced;

  // unresolved bits take the value of the last converted bit, or zero when none was converted
  function automatic logic [RES_W-1:0] fillPartial(input logic [RES_W-1:0] sar,
                                                   input logic [3:0] idx);
    logic [RES_W-1:0] res;
    logic last;
    res = sar;
    last = 1'b0;
    if (idx < 4'(RES_W)) begin
      if (idx != 4'(RES_W - 1)) begin
        last = sar[idx + 4'h1];
      end
      for (int i = 0; i < RES_W; i++) begin
        if (i <= int'(idx)) begin
          res[i] = last;
        end
      end
    end
    return res;
  endfunction : fillPartial

  // {high, low} byte pair for either justification
  function automatic logic [15:0] placeResult(input logic [RES_W-1:0] res,
                                              input logic right);
    if (right) begin
      return {6'h00, res};
    end
    return {res, 6'h00};
  endfunction : placeResult

  trigger_sync #(
    .N(TRIG_N)
  ) u_trig (
    .clk(clk),
    .resetn(resetn),
    .sources(trigSources),
    .sel(trigSel_r),
    .pulse(trigPulse)
  );

  tad_divider u_tad (
    .clk(clk),
    .resetn(resetn),
    .run(state_r == ST_CONV),
    .clkSel(clkSel_r),
    .rcHalfTick(rcHalfTick),
    .halfTick(halfTick)
  );

  always_comb begin
    rcSel = isRcClock(clkSel_r);
    idle = state_r == ST_IDLE;
    wrXfer = psel & penable & pwrite & pready;
    wrCtrl0 = wrXfer && paddr == OFS_CTRL0;
    // go only counts when enable was already set before this write
    swGoSet = wrCtrl0 & pwdata[BIT_GO] & pwdata[BIT_EN] & enable_r;
    swGoClr = wrCtrl0 & ~pwdata[BIT_GO] & ~idle;
    disableNow = wrCtrl0 & ~pwdata[BIT_EN] & ~idle;
    sleepAbort = sleepMode & ~rcSel & ~idle;
    abortAny = swGoClr | disableNow | sleepAbort;
    startOk = idle & enable_r & ~powerDown_r & (swGoSet | trigPulse)
              & ~(sleepMode & ~rcSel);
    resolveNow = state_r == ST_CONV && halfTick && !halfCnt_r[0]
                 && halfCnt_r >= 5'h02 && halfCnt_r <= 5'h14;
    complete = state_r == ST_CONV && halfTick && halfCnt_r == LAST_HALF
               && !abortAny;
    partialPlaced = placeResult(fillPartial(dacCode, bitIdx_r), justify_r);
    finalPlaced = placeResult(dacCode, justify_r);
  end

  // conversion sequence
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      halfCnt_r <= 5'h00;
      dlyCnt_r <= 3'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          halfCnt_r <= 5'h00;
          dlyCnt_r <= 3'h0;
          if (startOk) begin
            state_r <= rcSel ? ST_DELAY : ST_CONV;
          end
        end
        ST_DELAY: begin
          dlyCnt_r <= dlyCnt_r + 3'h1;
          if (abortAny) begin
            state_r <= ST_IDLE;
          end else if (dlyCnt_r == 3'(INSTR_CLKS - 1)) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (abortAny || complete) begin
            state_r <= ST_IDLE;
          end else if (halfTick) begin
            halfCnt_r <= halfCnt_r + 5'h01;
          end
        end
      endcase
    end
  end

  // successive approximation: trial bit out, comparator decides it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dacCode <= '0;
      bitIdx_r <= 4'hf;
    end else if (startOk) begin
      dacCode <= 10'h200;
      bitIdx_r <= 4'(RES_W - 1);
    end else if (resolveNow && bitIdx_r < 4'(RES_W)) begin
      dacCode[bitIdx_r] <= compIn;
      if (bitIdx_r != 4'h0) begin
        dacCode[bitIdx_r - 4'h1] <= 1'b1;
      end
      bitIdx_r <= bitIdx_r - 4'h1;
    end
  end

  // go flag reads busy for the whole conversion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      go_r <= 1'b0;
    end else if (startOk) begin
      go_r <= 1'b1;
    end else if (complete || abortAny) begin
      go_r <= 1'b0;
    end
  end

  // result registers; a sleep abort, or a disable that writes go as one, leaves them untouched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resH_r <= 8'h00;
      resL_r <= 8'h00;
    end else if (complete) begin
      {resH_r, resL_r} <= finalPlaced;
    end else if (swGoClr && state_r == ST_CONV) begin
      {resH_r, resL_r} <= partialPlaced;
    end
  end

  // done flag: completion wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      doneFlag_r <= 1'b0;
    end else if (complete) begin
      doneFlag_r <= 1'b1;
    end else if (wrXfer && paddr == OFS_STAT && pwdata[BIT_DONE]) begin
      doneFlag_r <= 1'b0;
    end
  end

  // sleep power management; enable bit is never touched here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      powerDown_r <= 1'b0;
      wakeRequest <= 1'b0;
      convOn <= 1'b0;
    end else begin
      if (!sleepMode) begin
        powerDown_r <= 1'b0;
      end else if (!rcSel || (complete && !irqEn_r)) begin
        powerDown_r <= 1'b1;
      end
      wakeRequest <= complete & sleepMode & irqEn_r;
      convOn <= enable_r & ~powerDown_r;
    end
  end

  // software-written configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enable_r <= 1'b0;
      chanSel <= RST_CHAN;
      justify_r <= 1'b0;
      clkSel_r <= RST_CLKSEL;
      refSel <= RST_PREF;
      trigSel_r <= RST_TRIG;
      irqEn_r <= 1'b0;
    end else if (wrXfer) begin
      unique case (paddr)
        OFS_CTRL0: begin
          enable_r <= pwdata[BIT_EN];
          chanSel <= pwdata[POS_CHAN +: 6];
        end
        OFS_CTRL1: begin
          justify_r <= pwdata[BIT_JUST];
          clkSel_r <= pwdata[POS_CLKSEL +: 3];
          refSel <= pwdata[POS_PREF +: 2];
        end
        OFS_TRIG: trigSel_r <= pwdata[TRIG_W-1:0];
        OFS_STAT: irqEn_r <= pwdata[BIT_IRQEN];
        default: begin
        end
      endcase
    end
  end

  // read mux and zero-wait answer: pready rises in every access phase
  always_comb begin
    rdMux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      OFS_CTRL0: rdMux[7:0] = {chanSel, go_r, enable_r};
      OFS_CTRL1: rdMux[7:0] = {justify_r, clkSel_r, 2'h0, refSel};
      OFS_TRIG: rdMux[TRIG_W-1:0] = trigSel_r;
      OFS_RESH: rdMux[7:0] = resH_r;
      OFS_RESL: rdMux[7:0] = resL_r;
      OFS_STAT: rdMux[1:0] = {irqEn_r, doneFlag_r};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // cycles spent converting, counted apart from halfCnt_r so the length check is independent
  logic [9:0] convCycles_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      convCycles_r <= 10'h000;
    end else if (state_r != ST_CONV) begin
      convCycles_r <= 10'h000;
    end else begin
      convCycles_r <= convCycles_r + 10'h001;
    end
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);

  chk_done_on_finish: assert property (complete |=> doneFlag_r && !go_r)
    else $error("done not set or go not cleared at completion");
  chk_go_while_busy: assert property (!idle |-> go_r)
    else $error("go low while conversion runs");
  chk_same_write_go: assert property (
    wrCtrl0 && !enable_r && pwdata[BIT_EN] && pwdata[BIT_GO] |=> !go_r)
    else $error("enabling write also started a conversion");
  chk_rc_start_delay: assert property (
    startOk && rcSel && !sleepMode && !trigPulse ##1 !abortAny[*4]
    |=> state_r == ST_CONV && $past(state_r, 4) == ST_DELAY)
    else $error("rc start not delayed by one instruction");
  chk_sleep_abort: assert property (sleepAbort |=> idle && !go_r && powerDown_r)
    else $error("sleep on system clock did not abort");
  chk_partial_value: assert property (
    swGoClr && state_r == ST_CONV |=> {resH_r, resL_r} == $past(partialPlaced))
    else $error("partial result not stored");
  chk_trigger_start: assert property (
    trigPulse && enable_r && idle && !powerDown_r && !sleepMode |=> go_r)
    else $error("trigger edge did not start a conversion");
  chk_sleep_wake: assert property (complete && sleepMode && irqEn_r |=> wakeRequest)
    else $error("no wake on sleep completion");
  chk_sleep_off: assert property (
    complete && sleepMode && !irqEn_r |=> powerDown_r && enable_r ##1 !convOn)
    else $error("converter not powered down after sleep completion");
  chk_conv_length: assert property (
    complete && clkSel_r == 3'h0 |-> convCycles_r == 10'h017)
    else $error("conversion ended at wrong half period");
  chk_sleep_no_start: assert property (sleepMode && !rcSel |=> !go_r)
    else $error("conversion running in sleep on system clock");
  chk_done_held: assert property (
    doneFlag_r && !(wrXfer && paddr == OFS_STAT && pwdata[BIT_DONE]) |=> doneFlag_r)
    else $error("done flag cleared without software");
  chk_result_held: assert property (
    !complete && !(swGoClr && state_r == ST_CONV) |=> $stable({resH_r, resL_r}))
    else $error("result changed outside completion or stop");
endmodule : adc_conversion_sequencer

//--- tb/adc_analog_model.sv
// analog side model: comparator against a held level and the free-running rc oscillator
// assumes dacCode is registered on clk; the decision is ready one cycle later
`timescale 1ns/1ps
module adc_analog_model #(
  parameter int RC_DIV = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [9:0] dacCode,
  input wire logic convOn,
  input wire logic [9:0] level,
  output logic compIn,
  output logic rcHalfTick
);
  int rcCnt;

  // powered down, the output toggles so a stale decision can never look valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compIn <= 1'b0;
    end else if (convOn) begin
      compIn <= (dacCode <= level);
    end else begin
      compIn <= ~compIn;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rcCnt <= 0;
      rcHalfTick <= 1'b0;
    end else begin
      rcCnt <= (rcCnt == RC_DIV - 1) ? 0 : rcCnt + 1;
      rcHalfTick <= (rcCnt == RC_DIV - 1);
    end
  end
endmodule : adc_analog_model

//--- tb/adc_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer, driven over APB
// assumes a zero-wait slave; the analog model answers compIn and rc ticks
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
  import adc_seq_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic sleepMode = 1'b0;
  logic [TRIG_N-1:0] trig = '0;
  logic [9:0] level = 10'h2a5;
  logic [31:0] prdata;
  logic pready, pslverr, rcHalfTick, compIn, convOn, wakeRequest;
  logic [5:0] chanSel;
  logic [1:0] refSel;
  logic lastErr = 1'b0;
  logic [RES_W-1:0] dacCode;
  int errorCnt = 0;
  int testsRun = 0;
  int wakes = 0;

  initial forever #20 clk = ~clk;

  adc_conversion_sequencer uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleepMode(sleepMode), .trigSources(trig), .rcHalfTick(rcHalfTick),
    .compIn(compIn), .dacCode(dacCode), .convOn(convOn), .chanSel(chanSel), .refSel(refSel),
    .wakeRequest(wakeRequest));

  adc_analog_model model (.clk(clk), .resetn(resetn), .dacCode(dacCode), .convOn(convOn),
    .level(level), .compIn(compIn), .rcHalfTick(rcHalfTick));

  always @(posedge clk) begin
    if (wakeRequest === 1'b1) begin
      wakes++;
    end
  end

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : giveVerdict

  task automatic hang(input string what);
    errorCnt++;
    $display("unexpected at %0t: timeout waiting for %s", $time, what);
    giveVerdict();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one transfer, released a full cycle before the next setup may start
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) hang("pready");
      @(posedge clk);
    end
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rdChk

  task automatic waitIdle();
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h2;
    while (q[BIT_GO] !== 1'b0) begin
      n++;
      if (n > 400) hang("go to clear");
      apb(1'b0, OFS_CTRL0, 32'h0, q);
    end
  endtask : waitIdle

  task automatic pulse(input int b);
    trig[b] <= 1'b1;
    repeat (2) @(posedge clk);
    trig[b] <= 1'b0;
  endtask : pulse

  task automatic sleepWait(input int w0);
    int n;
    n = 0;
    sleepMode <= 1'b1;
    while (wakes == w0 && convOn !== 1'b0) begin
      n++;
      if (n > 2000) hang("sleep completion");
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    sleepMode <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : sleepWait

  initial begin
    int w0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdChk(OFS_CTRL0, 32'h0);
    rdChk(OFS_STAT, 32'h0);
    rdChk(OFS_RESH + 8'h40, 32'h0);
    chk(lastErr, 32'h1);
    wr(OFS_CTRL0, 32'h0b);
    rdChk(OFS_CTRL0, 32'h09);
    chk(convOn, 1'b1);
    chk(chanSel, 32'h2);
    repeat (20) @(posedge clk);
    wr(OFS_CTRL0, 32'h0b);
    rdChk(OFS_CTRL0, 32'h0b);
    waitIdle();
    rdChk(OFS_STAT, 32'h1);
    rdChk(OFS_RESH, {24'h0, level[9:2]});
    rdChk(OFS_RESL, {24'h0, level[1:0], 6'h0});
    wr(OFS_STAT, 32'h1);
    rdChk(OFS_STAT, 32'h0);
    wr(OFS_CTRL1, 32'h80);
    level <= 10'h15a;
    wr(OFS_CTRL0, 32'h0b);
    waitIdle();
    rdChk(OFS_RESH, 32'h1);
    rdChk(OFS_RESL, 32'h5a);
    wr(OFS_STAT, 32'h1);
    // slow clock, stopped after two decisions: bit9 one, bit8 zero, rest copy zero
    level <= 10'h2a5;
    wr(OFS_CTRL1, 32'he0);
    wr(OFS_CTRL0, 32'h0b);
    repeat (185) @(posedge clk);
    wr(OFS_CTRL0, 32'h09);
    rdChk(OFS_CTRL0, 32'h09);
    rdChk(OFS_STAT, 32'h0);
    rdChk(OFS_RESH, 32'h2);
    rdChk(OFS_RESL, 32'h0);
    wr(OFS_CTRL0, 32'h0b);
    repeat (50) @(posedge clk);
    sleepMode <= 1'b1;
    repeat (3) @(posedge clk);
    chk(convOn, 1'b0);
    rdChk(OFS_CTRL0, 32'h09);
    rdChk(OFS_STAT, 32'h0);
    sleepMode <= 1'b0;
    repeat (3) @(posedge clk);
    chk(convOn, 1'b1);
    wr(OFS_CTRL1, 32'h31);
    rdChk(OFS_CTRL1, 32'h31);
    chk(refSel, 32'h1);
    wr(OFS_STAT, 32'h2);
    w0 = wakes;
    wr(OFS_CTRL0, 32'h0b);
    sleepWait(w0);
    chk(wakes - w0, 32'h1);
    rdChk(OFS_STAT, 32'h3);
    rdChk(OFS_RESH, {24'h0, level[9:2]});
    wr(OFS_STAT, 32'h1);
    w0 = wakes;
    wr(OFS_CTRL0, 32'h0b);
    sleepWait(w0);
    chk(wakes - w0, 32'h0);
    rdChk(OFS_CTRL0, 32'h09);
    rdChk(OFS_STAT, 32'h1);
    wr(OFS_CTRL1, 32'h0);
    wr(OFS_STAT, 32'h1);
    // codes past 0x12 are never programmed
    for (int c = 0; c <= TRIG_N; c++) begin
      wr(OFS_TRIG, 32'(c));
      pulse(c % TRIG_N);
      repeat (5) @(posedge clk);
      rdChk(OFS_CTRL0, 32'h09);
      if (c > 0) begin
        pulse(c - 1);
        repeat (6) @(posedge clk);
        rdChk(OFS_CTRL0, 32'h0b);
        waitIdle();
        rdChk(OFS_STAT, 32'h1);
        wr(OFS_STAT, 32'h1);
      end
    end
    wr(OFS_CTRL1, 32'he0);
    wr(OFS_CTRL0, 32'h0b);
    repeat (40) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(convOn, 1'b0);
    rdChk(OFS_CTRL0, 32'h0);
    rdChk(OFS_CTRL1, 32'h0);
    rdChk(OFS_RESH, 32'h0);
    chk(refSel, 32'h0);
    chk(lastErr, 32'h0);
    giveVerdict();
  end
endmodule : adc_conversion_sequencer_tb
